// >>> inc/sdmbo_pkg.sv
// sdmbo_pkg: field layout, encodings and sizes of the burst/latency configuration
package sdmbo_pkg;
	localparam int CFG_W   = 14;
	localparam int STORE_W = 12;
	localparam int COL_W   = 9;
	// field positions inside the configuration word
	localparam int BC_LSB    = 0;
	localparam int BC_W      = 3;
	localparam int ORDER_BIT = 3;
	localparam int RL_LSB    = 4;
	localparam int RL_W      = 3;
	localparam int OPM_LSB   = 7;
	localparam int WB_BIT    = 9;
	localparam int RSV_LSB   = 10;
	localparam int SEL_LSB   = 12;
	// burst count encodings
	localparam logic [2:0] BC_ONE   = 3'h0;
	localparam logic [2:0] BC_TWO   = 3'h1;
	localparam logic [2:0] BC_FOUR  = 3'h2;
	localparam logic [2:0] BC_EIGHT = 3'h3;
	localparam logic [2:0] BC_PAGE  = 3'h7;
	// read latency limits, in clocks
	localparam logic [2:0] RL_ONE   = 3'h1;
	localparam logic [2:0] RL_TWO   = 3'h2;
	localparam logic [2:0] RL_THREE = 3'h3;
	// register select and mode values
	localparam logic [1:0] SEL_BASE   = 2'h0;
	localparam logic [1:0] OPM_NORMAL = 2'h0;
	localparam logic [1:0] RSV_ZERO   = 2'h0;
	localparam logic [STORE_W-1:0] CFG_RST = 12'h000;
	// block masks: 512 columns x16, 256 columns x32
	localparam logic [COL_W-1:0] MASK_ONE   = 9'h000;
	localparam logic [COL_W-1:0] MASK_TWO   = 9'h001;
	localparam logic [COL_W-1:0] MASK_FOUR  = 9'h003;
	localparam logic [COL_W-1:0] MASK_EIGHT = 9'h007;
	localparam logic [COL_W-1:0] PAGE_X16   = 9'h1FF;
	localparam logic [COL_W-1:0] PAGE_X32   = 9'h0FF;
	localparam logic [COL_W-1:0] COL_ZERO   = 9'h000;
	localparam logic [COL_W-1:0] COL_ONE    = 9'h001;
	typedef enum logic [0:0] {
		SDMBO_IDLE  = 1'h0,
		SDMBO_BURST = 1'h1
	} sdmbo_state_t;
endpackage

// >>> design/sdmbo_cfg_reg.sv
// sdmbo_cfg_reg: configuration word storage and field decode
`timescale 1ns/1ns
module sdmbo_cfg_reg (
	input  wire logic                           clk_i,
	input  wire logic                           rst_b_i,
	input  wire logic                           load_i,
	input  wire logic [sdmbo_pkg::CFG_W-1:0]   addr_i,
	output logic      [sdmbo_pkg::STORE_W-1:0] cfg_o,
	output logic      [2:0]                     burst_count_o,
	output logic                                order_o,
	output logic      [2:0]                     latency_o,
	output logic      [1:0]                     op_mode_o,
	output logic                                write_burst_o,
	output logic                                normal_o,
	output logic                                bad_o
);
	import sdmbo_pkg::*;
	logic [STORE_W-1:0] cfg_r;
	logic [STORE_W-1:0] cfg_nxt;
	logic               sel_base;
	logic               bc_ok;
	logic               rl_ok;

	// only a load aimed at the base register changes the word
	assign sel_base = (addr_i[SEL_LSB +: 2] == SEL_BASE);
	assign cfg_nxt  = (load_i && sel_base) ? addr_i[STORE_W-1:0] : cfg_r;

	// no other write path exists; the word holds until reloaded
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			cfg_r <= CFG_RST;
		end else begin
			cfg_r <= cfg_nxt;
		end
	end

	// field slices
	assign cfg_o         = cfg_r;
	assign burst_count_o = cfg_r[BC_LSB +: BC_W];
	assign order_o       = cfg_r[ORDER_BIT];
	assign latency_o     = cfg_r[RL_LSB +: RL_W];
	assign op_mode_o     = cfg_r[OPM_LSB +: 2];
	assign write_burst_o = cfg_r[WB_BIT];
	// normal mode needs op mode and reserved bits all clear
	assign normal_o = (op_mode_o == OPM_NORMAL) && (cfg_r[RSV_LSB +: 2] == RSV_ZERO);
	// reserved codes are flagged, not rejected
	assign bc_ok = (burst_count_o == BC_ONE) || (burst_count_o == BC_TWO) ||
		(burst_count_o == BC_FOUR) || (burst_count_o == BC_EIGHT) ||
		(burst_count_o == BC_PAGE);
	assign rl_ok = (latency_o >= RL_ONE) && (latency_o <= RL_THREE);
	assign bad_o = !bc_ok || !rl_ok || !normal_o;
endmodule // sdmbo_cfg_reg

// >>> design/sdmbo_col_seq.sv
// sdmbo_col_seq: column of one burst beat from start, beat count and block mask
`timescale 1ns/1ns
module sdmbo_col_seq (
	input  wire logic [sdmbo_pkg::COL_W-1:0] start_i,
	input  wire logic [sdmbo_pkg::COL_W-1:0] cnt_i,
	input  wire logic [sdmbo_pkg::COL_W-1:0] mask_i,
	input  wire logic [sdmbo_pkg::COL_W-1:0] page_i,
	input  wire logic                        ilv_i,
	output logic      [sdmbo_pkg::COL_W-1:0] col_o
);
	import sdmbo_pkg::*;
	logic [COL_W-1:0] sum_w;
	logic [COL_W-1:0] off_w;
	logic [COL_W-1:0] blk_w;

	// sequential adds, interleaved xors; both wrap inside the mask
	assign sum_w = COL_W'(start_i + cnt_i);
	assign off_w = (ilv_i ? (start_i ^ cnt_i) : sum_w) & mask_i;
	// upper bits pick the aligned block and never change in a burst
	assign blk_w = start_i & ~mask_i & page_i;
	assign col_o = blk_w | off_w;
endmodule // sdmbo_col_seq

// >>> design/sdmbo_top.sv
// sdmbo_top: configuration register, burst column sequencer and read latency
//
// Contract
// - config word changes only on a load command and otherwise holds.
// - burst count comes from config bits zero to two.
// - config bit three picks sequential or interleaved column order.
// - read latency in clocks comes from config bits four to six.
// - operating mode decodes from config bits seven and eight.
// - config bit nine makes writes single-column or burst-length.
// - bursts of 1, 2, 4, 8 either order; full page sequential.
// - full-page burst runs until a burst-terminate command.
// - unterminated full-page burst wraps from last column to zero.
// - for 2, 4, 8 upper start bits pick block; wrap inside it.
// - low start bits below the block bits pick the first column.
// - sequential adds modulo block; interleaved xors start with beat count.
// - full-page bursts always run sequential, whatever the order bit.
// - page span is 512 columns x16, 256 columns x32.
// - full page uses the whole row, starting at all column bits.
// - burst of one accesses exactly the start column, order ignored.
// - latency 1 to 3; read data valid at edge n plus latency.
// - write-burst bit affects writes only; reads keep programmed length.
`timescale 1ns/1ns
module sdmbo_top (
	input  wire logic                         CLK_I,
	input  wire logic                         RST_B_I,
	input  wire logic                         CMD_LOAD_I,
	input  wire logic                         CMD_READ_I,
	input  wire logic                         CMD_WRITE_I,
	input  wire logic                         CMD_TERM_I,
	input  wire logic [sdmbo_pkg::CFG_W-1:0] ADDR_I,
	input  wire logic [sdmbo_pkg::COL_W-1:0] COL_I,
	input  wire logic                         ORG_X32_I,
	output logic      [sdmbo_pkg::COL_W-1:0] COL_O,
	output logic                              COL_VALID_O,
	output logic                              BURST_LAST_O,
	output logic                              BURST_WRITE_O,
	output logic                              RD_DATA_VALID_O,
	output logic      [sdmbo_pkg::COL_W-1:0] RD_COL_O,
	output logic      [2:0]                   BURST_COUNT_O,
	output logic                              BURST_ORDER_O,
	output logic      [2:0]                   READ_LATENCY_O,
	output logic      [1:0]                   OP_MODE_O,
	output logic                              WRITE_BURST_O,
	output logic                              NORMAL_MODE_O,
	output logic                              CONFIG_BAD_O
);
	import sdmbo_pkg::*;

	logic [STORE_W-1:0] cfg_w;
	sdmbo_state_t       state_r;
	sdmbo_state_t       state_nxt;
	logic [COL_W-1:0]   start_r;
	logic [COL_W-1:0]   cnt_r;
	logic [COL_W-1:0]   mask_r;
	logic [COL_W-1:0]   col_r;
	logic               ilv_r;
	logic               full_r;
	logic               write_r;
	logic               last_r;
	logic [1:0]         rd_pipe_r;
	logic [COL_W-1:0]   rd_col1_r;
	logic [COL_W-1:0]   rd_col2_r;
	logic               busy_w;
	logic               cmd_rw;
	logic               write_sel;
	logic               single_w;
	logic [2:0]         len_sel;
	logic [COL_W-1:0]   page_w;
	logic [COL_W-1:0]   mask_new;
	logic               full_new;
	logic               ilv_new;
	logic [COL_W-1:0]   st_sel;
	logic [COL_W-1:0]   cn_sel;
	logic [COL_W-1:0]   mk_sel;
	logic               il_sel;
	logic               fl_sel;
	logic [COL_W-1:0]   col_nxt;
	logic               last_nxt;
	logic               adv_w;
	logic               beat_rd;

	// configuration storage and decode
	sdmbo_cfg_reg u_cfg (
		.clk_i         (CLK_I),
		.rst_b_i       (RST_B_I),
		.load_i        (CMD_LOAD_I),
		.addr_i        (ADDR_I),
		.cfg_o         (cfg_w),
		.burst_count_o (BURST_COUNT_O),
		.order_o       (BURST_ORDER_O),
		.latency_o     (READ_LATENCY_O),
		.op_mode_o     (OP_MODE_O),
		.write_burst_o (WRITE_BURST_O),
		.normal_o      (NORMAL_MODE_O),
		.bad_o         (CONFIG_BAD_O)
	);

	// command decode; a read wins if both strobes arrive together
	assign busy_w    = (state_r == SDMBO_BURST);
	assign cmd_rw    = CMD_READ_I || CMD_WRITE_I;
	assign write_sel = CMD_WRITE_I && !CMD_READ_I;
	// single-location writes leave reads at the programmed length
	assign single_w  = write_sel && WRITE_BURST_O;
	assign len_sel   = single_w ? BC_ONE : BURST_COUNT_O;
	assign page_w    = ORG_X32_I ? PAGE_X32 : PAGE_X16;

	// block mask from the burst length; reserved codes act as length one
	always_comb begin
		mask_new = MASK_ONE;
		full_new = 1'b0;
		case (len_sel)
			BC_ONE: begin
				mask_new = MASK_ONE;
			end
			BC_TWO: begin
				mask_new = MASK_TWO;
			end
			BC_FOUR: begin
				mask_new = MASK_FOUR;
			end
			BC_EIGHT: begin
				mask_new = MASK_EIGHT;
			end
			BC_PAGE: begin
				mask_new = page_w;
				full_new = 1'b1;
			end
			default: begin
				mask_new = MASK_ONE;
			end
		endcase
	end

	// interleave is dropped on full page; a single beat ignores order anyway
	assign ilv_new = BURST_ORDER_O && !full_new;

	// a new command restarts the sequence at beat zero
	assign st_sel = cmd_rw ? COL_I : start_r;
	assign cn_sel = cmd_rw ? COL_ZERO : COL_W'(cnt_r + COL_ONE);
	assign mk_sel = cmd_rw ? mask_new : mask_r;
	assign il_sel = cmd_rw ? ilv_new : ilv_r;
	assign fl_sel = cmd_rw ? full_new : full_r;

	sdmbo_col_seq u_seq (
		.start_i (st_sel),
		.cnt_i   (cn_sel),
		.mask_i  (mk_sel),
		.page_i  (page_w),
		.ilv_i   (il_sel),
		.col_o   (col_nxt)
	);

	// fixed bursts end when the beat count reaches the mask; full page never
	assign last_nxt = (cn_sel == mk_sel) && !fl_sel;
	// terminate stops the burst at once; a new command preempts it
	assign adv_w = cmd_rw || (busy_w && !last_r && !CMD_TERM_I);

	// burst state machine
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			SDMBO_IDLE: begin
				if (cmd_rw) begin
					state_nxt = SDMBO_BURST;
				end
			end
			SDMBO_BURST: begin
				if (!adv_w) begin
					state_nxt = SDMBO_IDLE;
				end
			end
			default: begin
				state_nxt = SDMBO_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK_I) begin
		if (!RST_B_I) begin
			state_r <= SDMBO_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// burst context, loaded on a command and held until the next one
	always_ff @(posedge CLK_I) begin
		if (!RST_B_I) begin
			start_r <= COL_ZERO;
			mask_r  <= MASK_ONE;
			ilv_r   <= 1'b0;
			full_r  <= 1'b0;
			write_r <= 1'b0;
		end else if (cmd_rw) begin
			start_r <= COL_I;
			mask_r  <= mask_new;
			ilv_r   <= ilv_new;
			full_r  <= full_new;
			write_r <= write_sel;
		end
	end

	// column and beat counter; the page mask wraps full page to zero
	always_ff @(posedge CLK_I) begin
		if (!RST_B_I) begin
			col_r  <= COL_ZERO;
			cnt_r  <= COL_ZERO;
			last_r <= 1'b0;
		end else if (adv_w) begin
			col_r  <= col_nxt;
			cnt_r  <= cn_sel;
			last_r <= last_nxt;
		end else begin
			last_r <= 1'b0;
		end
	end

	// read beats delayed so data appears latency clocks after the command
	assign beat_rd = busy_w && !write_r;
	always_ff @(posedge CLK_I) begin
		if (!RST_B_I) begin
			rd_pipe_r <= 2'h0;
			rd_col1_r <= COL_ZERO;
			rd_col2_r <= COL_ZERO;
		end else begin
			rd_pipe_r <= {rd_pipe_r[0], beat_rd};
			rd_col1_r <= col_r;
			rd_col2_r <= rd_col1_r;
		end
	end

	// latency taps; reserved latency codes fall back to three clocks
	assign RD_DATA_VALID_O = (READ_LATENCY_O == RL_ONE) ? beat_rd :
		(READ_LATENCY_O == RL_TWO) ? rd_pipe_r[0] : rd_pipe_r[1];
	assign RD_COL_O = (READ_LATENCY_O == RL_ONE) ? col_r :
		(READ_LATENCY_O == RL_TWO) ? rd_col1_r : rd_col2_r;

	// beat outputs straight from flip-flops
	assign COL_O         = col_r;
	assign COL_VALID_O   = busy_w;
	assign BURST_LAST_O  = last_r;
	assign BURST_WRITE_O = write_r;

	// checks on the configuration word
	chk_cfg_hold: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		!CMD_LOAD_I |=> $stable(cfg_w))
		else $error("config word changed without a load");
	chk_bc_field: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		CMD_LOAD_I && (ADDR_I[SEL_LSB +: 2] == SEL_BASE)
		|=> BURST_COUNT_O == $past(ADDR_I[2:0]))
		else $error("burst count not taken from bits zero to two");
	chk_order_field: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		CMD_LOAD_I && (ADDR_I[SEL_LSB +: 2] == SEL_BASE)
		|=> BURST_ORDER_O == $past(ADDR_I[3]))
		else $error("order bit not taken from bit three");
	chk_lat_field: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		CMD_LOAD_I && (ADDR_I[SEL_LSB +: 2] == SEL_BASE)
		|=> READ_LATENCY_O == $past(ADDR_I[6:4]))
		else $error("latency not taken from bits four to six");
	chk_mode_field: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		CMD_LOAD_I && (ADDR_I[SEL_LSB +: 2] == SEL_BASE)
		|=> OP_MODE_O == $past(ADDR_I[8:7]) && WRITE_BURST_O == $past(ADDR_I[9]))
		else $error("mode or write-burst bit not loaded");
	chk_ext_ignored: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		CMD_LOAD_I && (ADDR_I[SEL_LSB +: 2] != SEL_BASE) |=> $stable(cfg_w))
		else $error("base word written by another register select");

	// checks on burst length and column order
	chk_write_single: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		write_sel && WRITE_BURST_O
		|=> COL_VALID_O && BURST_LAST_O && COL_O == ($past(COL_I) & page_w))
		else $error("single-location write did not end after one beat");
	chk_read_len: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		CMD_READ_I && BURST_COUNT_O == BC_EIGHT |=> !BURST_LAST_O)
		else $error("eight-beat read ended early");
	chk_last_beat: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		BURST_LAST_O |-> COL_VALID_O && cnt_r == mask_r && !full_r)
		else $error("last beat at wrong count");
	chk_page_open: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		COL_VALID_O && full_r && !CMD_TERM_I && !cmd_rw |=> COL_VALID_O)
		else $error("full-page burst stopped without terminate");
	chk_first_col: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		cmd_rw |=> COL_VALID_O && cnt_r == COL_ZERO && COL_O == ($past(COL_I) & page_w))
		else $error("first column is not the start column");
	chk_block_keep: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		COL_VALID_O |-> ((COL_O ^ start_r) & ~mask_r & page_w) == COL_ZERO)
		else $error("burst left its aligned block");
	chk_seq_step: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		COL_VALID_O && !ilv_r && $past(COL_VALID_O) && !$past(cmd_rw)
		|-> (COL_O & mask_r) == (COL_W'($past(COL_O) + COL_ONE) & mask_r))
		else $error("sequential step is not plus one modulo block");
	chk_ilv_order: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		COL_VALID_O && ilv_r |-> ((COL_O ^ start_r) & mask_r) == (cnt_r & mask_r))
		else $error("interleaved column is not start xor beat");
	chk_page_seq: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		COL_VALID_O && full_r |-> !ilv_r && mask_r == page_w)
		else $error("full page not sequential over the row");
	chk_page_wrap: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		COL_VALID_O && full_r && COL_O == page_w && !CMD_TERM_I && !cmd_rw
		|=> COL_O == COL_ZERO)
		else $error("full page did not wrap to column zero");

	// check on read latency
	chk_rd_lat2: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		$rose(COL_VALID_O) && !BURST_WRITE_O && READ_LATENCY_O == RL_TWO
		|-> !RD_DATA_VALID_O ##1 RD_DATA_VALID_O && RD_COL_O == $past(COL_O))
		else $error("read data not valid two clocks after command");

	// main scenarios
	cov_page_term: cover property (@(posedge CLK_I) disable iff (!RST_B_I)
		COL_VALID_O && full_r && COL_O == page_w ##1 CMD_TERM_I);
	cov_ilv_eight: cover property (@(posedge CLK_I) disable iff (!RST_B_I)
		COL_VALID_O && ilv_r && mask_r == MASK_EIGHT && BURST_LAST_O);
	cov_rd_lat3: cover property (@(posedge CLK_I) disable iff (!RST_B_I)
		RD_DATA_VALID_O && READ_LATENCY_O == RL_THREE);
endmodule // sdmbo_top

// >>> verif/sdmbo_ctrl_model.sv
// sdmbo_ctrl_model: behavioural memory controller that drives the command pins
`timescale 1ns/1ns
module sdmbo_ctrl_model #(
	parameter int MRD_CYC = 2
) (
	input  wire logic                         clk_i,
	output logic                              load_o,
	output logic                              read_o,
	output logic                              write_o,
	output logic                              term_o,
	output logic      [sdmbo_pkg::CFG_W-1:0] addr_o,
	output logic      [sdmbo_pkg::COL_W-1:0] col_o
);
	import sdmbo_pkg::*;

	// quiet bus at time zero, before the first command
	initial begin
		load_o  = 1'h0;
		read_o  = 1'h0;
		write_o = 1'h0;
		term_o  = 1'h0;
		addr_o  = '0;
		col_o   = '0;
	end

	// released address lines flip, so a design that keeps sampling them shows it
	task idle();
		load_o  = 1'h0;
		read_o  = 1'h0;
		write_o = 1'h0;
		term_o  = 1'h0;
		addr_o  = ~addr_o;
		col_o   = ~col_o;
	endtask

	// one load pulse; the caller keeps every bank idle while this runs
	task load(input logic [2:0] bc, input logic ilv, input logic [2:0] cl,
		input logic wb, input logic [1:0] sel);
		@(negedge clk_i);
		load_o = 1'h1;
		// op mode and reserved bits always zero; sel and bc as the scenario asks
		addr_o = {sel, RSV_ZERO, wb, OPM_NORMAL, cl, ilv, bc};
		@(negedge clk_i);
		idle();
		// settle time before any further command
		repeat (MRD_CYC) @(negedge clk_i);
	endtask

	// read or write pulse; the caller releases it at the next falling edge
	task cmd(input logic rd, input logic [COL_W-1:0] col);
		@(negedge clk_i);
		read_o  = rd;
		write_o = ~rd;
		col_o   = col;
	endtask

	// terminate pulse, released by the caller's next idle
	task term();
		term_o = 1'h1;
	endtask
endmodule // sdmbo_ctrl_model

// >>> verif/testbench.sv
// testbench: command sequences against the burst and configuration block
`timescale 1ns/1ns
module testbench;
	import sdmbo_pkg::*;

	logic             CLK_I;
	logic             RST_B_I;
	logic             ORG_X32_I;
	logic             ld;
	logic             rd;
	logic             wr;
	logic             tm;
	logic [CFG_W-1:0] addr;
	logic [COL_W-1:0] col;
	logic [COL_W-1:0] COL_O;
	logic [COL_W-1:0] RD_COL_O;
	logic             COL_VALID_O;
	logic             BURST_LAST_O;
	logic             BURST_WRITE_O;
	logic             RD_DATA_VALID_O;
	logic [2:0]       BURST_COUNT_O;
	logic             BURST_ORDER_O;
	logic [2:0]       READ_LATENCY_O;
	logic [1:0]       OP_MODE_O;
	logic             WRITE_BURST_O;
	logic             NORMAL_MODE_O;
	logic             CONFIG_BAD_O;
	int               failures;
	int               num_checks;
	logic [COL_W-1:0] starts [2] = '{9'h005, 9'h1FE};

	sdmbo_top i_sdmbo_top (.CLK_I(CLK_I), .RST_B_I(RST_B_I), .CMD_LOAD_I(ld),
		.CMD_READ_I(rd), .CMD_WRITE_I(wr), .CMD_TERM_I(tm), .ADDR_I(addr),
		.COL_I(col), .ORG_X32_I(ORG_X32_I), .COL_O(COL_O),
		.COL_VALID_O(COL_VALID_O), .BURST_LAST_O(BURST_LAST_O),
		.BURST_WRITE_O(BURST_WRITE_O), .RD_DATA_VALID_O(RD_DATA_VALID_O),
		.RD_COL_O(RD_COL_O), .BURST_COUNT_O(BURST_COUNT_O),
		.BURST_ORDER_O(BURST_ORDER_O), .READ_LATENCY_O(READ_LATENCY_O),
		.OP_MODE_O(OP_MODE_O), .WRITE_BURST_O(WRITE_BURST_O),
		.NORMAL_MODE_O(NORMAL_MODE_O), .CONFIG_BAD_O(CONFIG_BAD_O));

	sdmbo_ctrl_model i_sdmbo_ctrl_model (.clk_i(CLK_I), .load_o(ld), .read_o(rd),
		.write_o(wr), .term_o(tm), .addr_o(addr), .col_o(col));

	// 250 MHz clock
	initial begin
		CLK_I = 1'h0;
		forever #2 CLK_I = ~CLK_I;
	end

	task finish_test();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task chk(input string name, input logic [COL_W-1:0] exp, input logic [COL_W-1:0] got);
		num_checks++;
		if (got !== exp) begin
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
			failures++;
		end
	endtask

	// block bits kept from the start, offset wraps inside the mask
	function logic [COL_W-1:0] ecol(input logic [COL_W-1:0] s, input int k,
		input logic [COL_W-1:0] m, input logic ilv);
		logic [COL_W-1:0] kk;
		kk = k[COL_W-1:0];
		return (s & ~m) | ((ilv ? (s ^ kk) : (s + kk)) & m);
	endfunction

	task fields(input logic [2:0] bc, input logic ilv, input logic [2:0] cl,
		input logic wb, input logic bad);
		chk("count", bc, BURST_COUNT_O);
		chk("order", ilv, BURST_ORDER_O);
		chk("latency", cl, READ_LATENCY_O);
		chk("op_mode", OPM_NORMAL, OP_MODE_O);
		chk("normal", 1'h1, NORMAL_MODE_O);
		chk("write_burst", wb, WRITE_BURST_O);
		chk("bad", bad, CONFIG_BAD_O);
	endtask

	// one burst, sampled each falling edge; page bursts end by terminate after len beats
	task run(input logic isrd, input logic [COL_W-1:0] s, input int len,
		input logic [COL_W-1:0] m, input logic ilv, input int cl, input logic page);
		int j;
		int k;
		i_sdmbo_ctrl_model.cmd(isrd, s);
		for (j = 1; j <= len + cl + 1; j++) begin
			@(negedge CLK_I);
			if (page && j == len)
				i_sdmbo_ctrl_model.term();
			else
				i_sdmbo_ctrl_model.idle();
			k = j - 1;
			chk("col_valid", k < len, COL_VALID_O);
			if (k < len) begin
				chk("col", ecol(s, k, m, ilv), COL_O);
				chk("last", !page && k == len - 1, BURST_LAST_O);
				chk("is_write", !isrd, BURST_WRITE_O);
			end
			k = j - cl;
			chk("rd_valid", isrd && k >= 0 && k < len, RD_DATA_VALID_O);
			if (isrd && k >= 0 && k < len)
				chk("rd_col", ecol(s, k, m, ilv), RD_COL_O);
		end
	endtask

	// a hang anywhere ends the run as a failure
	initial begin
		repeat (20000) @(posedge CLK_I);
		failures++;
		finish_test();
	end

	initial begin
		RST_B_I   = 1'h0;
		ORG_X32_I = 1'h0;
		failures  = 0;
		num_checks = 0;
		repeat (5) @(negedge CLK_I);
		RST_B_I = 1'h1;
		fields(BC_ONE, 1'h0, 3'h0, 1'h0, 1'h1);
		chk("col_valid", 1'h0, COL_VALID_O);
		// every field in one load, then a load aimed at the other register
		i_sdmbo_ctrl_model.load(BC_FOUR, 1'h1, RL_THREE, 1'h1, SEL_BASE);
		fields(BC_FOUR, 1'h1, RL_THREE, 1'h1, 1'h0);
		i_sdmbo_ctrl_model.load(BC_TWO, 1'h0, RL_ONE, 1'h0, 2'h1);
		repeat (4) @(negedge CLK_I);
		fields(BC_FOUR, 1'h1, RL_THREE, 1'h1, 1'h0);
		// reserved count code is flagged and runs one beat
		i_sdmbo_ctrl_model.load(3'h4, 1'h0, RL_TWO, 1'h0, SEL_BASE);
		fields(3'h4, 1'h0, RL_TWO, 1'h0, 1'h1);
		run(1'h1, 9'h005, 1, MASK_ONE, 1'h0, 2, 1'h0);
		// all fixed lengths, both orders, two starts, reads and writes
		for (int b = 0; b < 4; b++) begin
			for (int o = 0; o < 2; o++) begin
				for (int s = 0; s < 2; s++) begin
					i_sdmbo_ctrl_model.load(b[2:0], o[0], RL_TWO, 1'h0, SEL_BASE);
					run(s == 0, starts[s], 1 << b, 9'((1 << b) - 1), o[0], 2, 1'h0);
				end
			end
		end
		// each read latency
		for (int c = 1; c <= 3; c++) begin
			i_sdmbo_ctrl_model.load(BC_TWO, 1'h0, c[2:0], 1'h0, SEL_BASE);
			run(1'h1, 9'h0A3, 2, MASK_TWO, 1'h0, c, 1'h0);
		end
		// reserved latency code is flagged and taps at three clocks
		i_sdmbo_ctrl_model.load(BC_TWO, 1'h0, 3'h5, 1'h0, SEL_BASE);
		fields(BC_TWO, 1'h0, 3'h5, 1'h0, 1'h1);
		run(1'h1, 9'h0A3, 2, MASK_TWO, 1'h0, 3, 1'h0);
		// terminate outside a burst must not start one
		@(negedge CLK_I);
		i_sdmbo_ctrl_model.term();
		@(negedge CLK_I);
		i_sdmbo_ctrl_model.idle();
		chk("col_valid", 1'h0, COL_VALID_O);
		// single-column writes, reads keep the programmed length
		i_sdmbo_ctrl_model.load(BC_FOUR, 1'h0, RL_ONE, 1'h1, SEL_BASE);
		run(1'h0, 9'h006, 1, MASK_ONE, 1'h0, 0, 1'h0);
		run(1'h1, 9'h006, 4, MASK_FOUR, 1'h0, 1, 1'h0);
		// full page with order bit set still runs sequential and wraps to zero
		i_sdmbo_ctrl_model.load(BC_PAGE, 1'h1, RL_TWO, 1'h0, SEL_BASE);
		run(1'h0, 9'h1FD, 5, PAGE_X16, 1'h0, 0, 1'h1);
		ORG_X32_I = 1'h1;
		run(1'h0, 9'h0FE, 3, PAGE_X32, 1'h0, 0, 1'h1);
		finish_test();
	end
endmodule // testbench
